// File: design/uswr_params.svh
`ifndef USWR_PARAMS_SVH
`define USWR_PARAMS_SVH
// clock and timing
`define USWR_CLK_HZ 25000000
`define USWR_CLK_MHZ 25
`define USWR_WAKE_MIN_US 18
`define USWR_WAKE_MAX_US 65
// least wait is exact, no rounding: 18 us at 25 MHz gives 450 cycles
`define USWR_WAKE_MIN_CYC ((`USWR_WAKE_MIN_US * `USWR_CLK_MHZ) + 0)
// fixed standby line rate
`define USWR_STBY_BPS 4800
// width of divider counters and of the wake counter
`define USWR_DIV_W 16
`define USWR_WAKE_W 12
// frame layout
`define USWR_DATA_BITS 8
`define USWR_BIT_CNT_W 4
`define USWR_PAR_BIT 4'h8
`define USWR_STOP_BIT_NP 4'h8
`define USWR_STOP_BIT_P 4'h9
// upper divider field position in the channel data word
`define USWR_DIV_HI 15
`define USWR_DIV_LO 9
// fifo shape
`define USWR_FIFO_W 8
`define USWR_FIFO_D 16
`define USWR_FIFO_AW 4
`endif

// File: design/uswr_pkg.sv
package uswr_pkg;
  // receiver states
  typedef enum logic [1:0] {
    USWR_IDLE = 2'b00,
    USWR_START = 2'b01,
    USWR_DATA = 2'b10
  } uswr_state_type;
  // error event bundle of one frame
  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
  } uswr_err_type;
endpackage

// File: design/uswr_fifo.sv
`timescale 1ns/1ps
`include "uswr_params.svh"
module uswr_fifo #(
  parameter int WIDTH = `USWR_FIFO_W,
  parameter int DEPTH = `USWR_FIFO_D,
  parameter int AW = `USWR_FIFO_AW
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  // full and empty come from the occupancy count
  always_comb begin
    push = in_valid && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    pop = out_ready && (cnt_r != '0);
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
endmodule // uswr_fifo

// File: design/uswr_receiver.sv
`timescale 1ns/1ps
`include "uswr_params.svh"
// Functional notes
// - in deep halt with standby enabled the receiver keeps running
// - standby support exists only on channel zero, or zero and two
// - start-bit falling edge after halt begins frame reception
// - standby line rate is 4800 bps only
// - with wake bit set, frames started outside halt are unreliable
// - in standby, suppression bit blocks parity, framing, overrun flags and irq
// - standby reception only after 18 to 65 us transition delay
module uswr_receiver
  import uswr_pkg::*;
#(
  parameter bit CHANNEL_HAS_STANDBY = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serial_receive_pin,
  input wire logic channel_start_bit,
  input wire logic standby_wake_ctrl_bit,
  input wire logic deep_halt,
  input wire logic fast_osc_selected,
  input wire logic error_irq_enable_bit,
  input wire logic standby_error_suppress_bit,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic [2:0] prescaler_select_reg,
  input wire logic [15:0] channel_data_reg,
  input wire logic flag_clear,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic reception_complete_req,
  output logic receive_error_irq,
  output logic parity_error_flag,
  output logic framing_error_flag,
  output logic overrun_error_flag,
  output logic standby_active
);
  //////////////////////////////////////////////////////////////////////
  // reset release and pin synchroniser
  logic rst_s1_r, rst_s2_r, rst_i_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_i_b = rst_s2_r;
  logic pin_s1_r, pin_s2_r, pin_d_r;
  // only the second stage and its delayed copy pin_d_r are read by logic
  always_ff @(posedge clock or negedge rst_i_b) begin
    if (!rst_i_b) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r <= 1'b1;
    end else begin
      pin_s1_r <= serial_receive_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // standby arming and transition wait
  logic [`USWR_WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;
  logic stby_r, stby_nxt, arm_ok;
  // standby needs the channel, the fast oscillator, the wake bit and deep halt
  assign arm_ok = CHANNEL_HAS_STANDBY && fast_osc_selected
                  && standby_wake_ctrl_bit && deep_halt;
  always_comb begin
    wake_cnt_nxt = wake_cnt_r;
    stby_nxt = stby_r;
    if (!arm_ok) begin
      wake_cnt_nxt = '0;
      stby_nxt = 1'b0;
    end else if (wake_cnt_r != `USWR_WAKE_W'(`USWR_WAKE_MIN_CYC)) begin
      wake_cnt_nxt = wake_cnt_r + 1'b1;
    end else begin
      stby_nxt = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_i_b) begin
    if (!rst_i_b) begin
      wake_cnt_r <= '0;
      stby_r <= 1'b0;
    end else begin
      wake_cnt_r <= wake_cnt_nxt;
      stby_r <= stby_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // bit timing: prescaler 2^n, divider (field+1)*2 per bit
  logic run_en, in_stby_mode;
  // with wake bit set the receiver only listens once standby is reached;
  // earlier starts are refused rather than received wrong
  assign in_stby_mode = standby_wake_ctrl_bit;
  assign run_en = channel_start_bit
                  && (!in_stby_mode || stby_r);
  logic [`USWR_DIV_W-1:0] bit_len;
  logic [6:0] div_field;
  assign div_field = channel_data_reg[`USWR_DIV_HI:`USWR_DIV_LO];
  // one bit lasts 2^ps * 2 * (field + 1) clocks; at 4800 bps in
  // standby the software picks ps and field for the oscillator
  assign bit_len = `USWR_DIV_W'((({9'h000, div_field} + 16'h0001)
                   << 1) << prescaler_select_reg);
  //////////////////////////////////////////////////////////////////////
  // receive state machine
  uswr_state_type st_r, st_nxt;
  logic [`USWR_DIV_W-1:0] tick_r, tick_nxt;
  logic [`USWR_BIT_CNT_W-1:0] bit_r, bit_nxt;
  logic [7:0] shf_r, shf_nxt;
  logic par_r, par_nxt;
  logic done, push_ok, fifo_in_ready;
  uswr_err_type ev;
  logic [`USWR_BIT_CNT_W-1:0] stop_idx;
  assign stop_idx = parity_enable ? `USWR_STOP_BIT_P : `USWR_STOP_BIT_NP;
  always_comb begin
    st_nxt = st_r;
    tick_nxt = tick_r;
    bit_nxt = bit_r;
    shf_nxt = shf_r;
    par_nxt = par_r;
    done = 1'b0;
    ev = '0;
    unique case (st_r)
      USWR_IDLE: begin
        // falling edge on the pin is the start bit
        if (run_en && pin_d_r && !pin_s2_r) begin
          st_nxt = USWR_START;
          tick_nxt = bit_len >> 1;
        end
      end
      USWR_START: begin
        if (tick_r != '0) begin
          tick_nxt = tick_r - 1'b1;
        end else if (pin_s2_r) begin
          st_nxt = USWR_IDLE; // glitch, not a start bit
        end else begin
          st_nxt = USWR_DATA;
          tick_nxt = bit_len - 1'b1;
          bit_nxt = '0;
          par_nxt = parity_odd;
        end
      end
      USWR_DATA: begin
        if (tick_r != '0) begin
          tick_nxt = tick_r - 1'b1;
        end else begin
          tick_nxt = bit_len - 1'b1;
          bit_nxt = bit_r + 1'b1;
          if (bit_r < `USWR_BIT_CNT_W'(`USWR_DATA_BITS)) begin
            shf_nxt = {pin_s2_r, shf_r[7:1]}; // lsb first
            par_nxt = par_r ^ pin_s2_r;
          end else if (parity_enable && bit_r == `USWR_PAR_BIT) begin
            par_nxt = par_r ^ pin_s2_r;
          end
          if (bit_r == stop_idx) begin
            st_nxt = USWR_IDLE;
            done = 1'b1;
            ev.framing = !pin_s2_r;
            ev.parity = parity_enable && par_r;
            ev.overrun = !fifo_in_ready;
          end
        end
      end
      default: st_nxt = USWR_IDLE;
    endcase
    if (!channel_start_bit) begin
      st_nxt = USWR_IDLE;
    end
  end
  always_ff @(posedge clock or negedge rst_i_b) begin
    if (!rst_i_b) begin
      st_r <= USWR_IDLE;
      tick_r <= '0;
      bit_r <= '0;
      shf_r <= '0;
      par_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      par_r <= par_nxt;
    end
  end
  // overrun frames are dropped, keeping older words intact
  assign push_ok = done && fifo_in_ready;
  //////////////////////////////////////////////////////////////////////
  // error flags, interrupt and completion request
  logic pef_r, fef_r, ovf_r, irq_r, cmp_r;
  logic pef_nxt, fef_nxt, ovf_nxt, irq_nxt, cmp_nxt, sup;
  assign sup = standby_error_suppress_bit && stby_r;
  always_comb begin
    // set beats clear in the same cycle
    pef_nxt = (pef_r && !flag_clear) || (ev.parity && !sup);
    fef_nxt = (fef_r && !flag_clear) || (ev.framing && !sup);
    ovf_nxt = (ovf_r && !flag_clear) || (ev.overrun && !sup);
    irq_nxt = error_irq_enable_bit && !sup
              && (ev.parity || ev.framing || ev.overrun);
    cmp_nxt = push_ok && stby_r;
  end
  always_ff @(posedge clock or negedge rst_i_b) begin
    if (!rst_i_b) begin
      pef_r <= 1'b0;
      fef_r <= 1'b0;
      ovf_r <= 1'b0;
      irq_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      pef_r <= pef_nxt;
      fef_r <= fef_nxt;
      ovf_r <= ovf_nxt;
      irq_r <= irq_nxt;
      cmp_r <= cmp_nxt;
    end
  end
  assign parity_error_flag = pef_r;
  assign framing_error_flag = fef_r;
  assign overrun_error_flag = ovf_r;
  assign receive_error_irq = irq_r;
  assign reception_complete_req = cmp_r;
  assign standby_active = stby_r;
  //////////////////////////////////////////////////////////////////////
  // received bytes wait in the fifo; a stalled reader causes overrun
  logic fifo_valid, fifo_take;
  logic [7:0] fifo_data;
  uswr_fifo #(
    .WIDTH(`USWR_FIFO_W),
    .DEPTH(`USWR_FIFO_D),
    .AW(`USWR_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_i_b),
    .in_valid(push_ok),
    .in_ready(fifo_in_ready),
    .in_data(shf_r),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );
  // output stage so the reader sees flops; it refills whenever empty or
  // being taken, so back to back reads lose no cycle
  logic out_v_r, out_v_nxt;
  logic [7:0] out_d_r, out_d_nxt;
  assign fifo_take = !out_v_r || rx_ready;
  always_comb begin
    out_v_nxt = out_v_r && !rx_ready;
    out_d_nxt = out_d_r;
    if (fifo_valid && fifo_take) begin
      out_v_nxt = 1'b1;
      out_d_nxt = fifo_data;
    end
  end
  always_ff @(posedge clock or negedge rst_i_b) begin
    if (!rst_i_b) begin
      out_v_r <= 1'b0;
      out_d_r <= '0;
    end else begin
      out_v_r <= out_v_nxt;
      out_d_r <= out_d_nxt;
    end
  end
  assign rx_valid = out_v_r;
  assign rx_data = out_d_r;
  //////////////////////////////////////////////////////////////////////
  // checks
  property p_suppress_flags;
    @(posedge clock) disable iff (!rst_i_b)
    (sup && !flag_clear) |=> !$rose(pef_r) && !$rose(fef_r)
                             && !$rose(ovf_r);
  endproperty
  a_suppress_flags: assert property (p_suppress_flags)
    else $error("error flag rose while suppressed");
  property p_suppress_irq;
    @(posedge clock) disable iff (!rst_i_b)
    sup |=> !irq_r;
  endproperty
  a_suppress_irq: assert property (p_suppress_irq)
    else $error("error irq while suppressed");
  property p_wake_delay;
    @(posedge clock) disable iff (!rst_i_b)
    $rose(stby_r)
      |-> $past(wake_cnt_r) == `USWR_WAKE_W'(`USWR_WAKE_MIN_CYC);
  endproperty
  a_wake_delay: assert property (p_wake_delay)
    else $error("standby entered before transition delay");
  property p_no_stby_unarmed;
    @(posedge clock) disable iff (!rst_i_b)
    !arm_ok |=> !stby_r;
  endproperty
  a_no_stby_unarmed: assert property (p_no_stby_unarmed)
    else $error("standby without arming");
  property p_start_edge;
    @(posedge clock) disable iff (!rst_i_b)
    (st_r == USWR_IDLE && run_en && pin_d_r && !pin_s2_r
     && channel_start_bit) |=> st_r == USWR_START;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start edge ignored");
  property p_refuse_early;
    @(posedge clock) disable iff (!rst_i_b)
    (st_r == USWR_IDLE && standby_wake_ctrl_bit && !stby_r)
      |=> st_r == USWR_IDLE;
  endproperty
  a_refuse_early: assert property (p_refuse_early)
    else $error("frame started outside standby");
  property p_complete;
    @(posedge clock) disable iff (!rst_i_b)
    (push_ok && stby_r) |=> reception_complete_req;
  endproperty
  a_complete: assert property (p_complete)
    else $error("missing completion request");
  property p_channel_gate;
    @(posedge clock) disable iff (!rst_i_b)
    (!CHANNEL_HAS_STANDBY || !fast_osc_selected) |=> !stby_r;
  endproperty
  a_channel_gate: assert property (p_channel_gate)
    else $error("standby on unsupported channel or clock");
endmodule // uswr_receiver

// File: test/uswr_serial_sender.sv
`timescale 1ns/1ps
// remote transmitter: drives the receive line, idle high between frames
module uswr_serial_sender #(
  parameter int BIT_CLKS = 8
) (
  input wire logic clock,
  output logic serial_line
);
  initial serial_line = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // one bit cell; every cell lasts the same fixed time
  task automatic send_bit(input logic v);
    serial_line <= v;
    repeat (BIT_CLKS) @(posedge clock);
  endtask
  // lsb first, optional parity, one stop; the bench picks the stop level
  task automatic send(input logic [7:0] d, input logic par_on,
      input logic odd, input logic par_bad, input logic stop_v);
    int i;
    @(posedge clock);
    send_bit(1'b0);
    for (i = 0; i < 8; i++) begin
      send_bit(d[i]);
    end
    if (par_on) begin
      send_bit((^d) ^ odd ^ par_bad);
    end
    send_bit(stop_v);
    send_bit(1'b1); // idle gap, so a low stop bit never looks like a start
  endtask
endmodule // uswr_serial_sender

// File: test/uswr_receiver_test.sv
`timescale 1ns/1ps
module uswr_receiver_test;
  // ps 0, divider field 3: 2*(3+1) clocks a bit, to keep the run short
  localparam int BIT_CLKS = 8;
  logic clock, rst_b, serial_receive_pin, channel_start_bit;
  logic standby_wake_ctrl_bit, deep_halt, fast_osc_selected;
  logic error_irq_enable_bit, standby_error_suppress_bit;
  logic parity_enable, parity_odd, flag_clear, rx_valid, rx_ready;
  logic reception_complete_req, receive_error_irq, standby_active;
  logic parity_error_flag, framing_error_flag, overrun_error_flag;
  logic [2:0] prescaler_select_reg;
  logic [15:0] channel_data_reg;
  logic [7:0] rx_data, got_byte;
  logic [31:0] lfsr;
  logic [7:0] exp_q[$];
  int fails = 0;
  int total_checks = 0;
  int done_cnt = 0;
  int irq_cnt = 0;
  //////////////////////////////////////////////////////////////////////////////
  uswr_serial_sender #(.BIT_CLKS(BIT_CLKS)) tx (.clock(clock),
    .serial_line(serial_receive_pin));
  uswr_receiver dut (.clock(clock), .rst_b(rst_b),
    .serial_receive_pin(serial_receive_pin),
    .channel_start_bit(channel_start_bit),
    .standby_wake_ctrl_bit(standby_wake_ctrl_bit), .deep_halt(deep_halt),
    .fast_osc_selected(fast_osc_selected),
    .error_irq_enable_bit(error_irq_enable_bit),
    .standby_error_suppress_bit(standby_error_suppress_bit),
    .parity_enable(parity_enable), .parity_odd(parity_odd),
    .prescaler_select_reg(prescaler_select_reg),
    .channel_data_reg(channel_data_reg), .flag_clear(flag_clear),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .reception_complete_req(reception_complete_req),
    .receive_error_irq(receive_error_irq),
    .parity_error_flag(parity_error_flag),
    .framing_error_flag(framing_error_flag),
    .overrun_error_flag(overrun_error_flag),
    .standby_active(standby_active));
  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // one-cycle pulses are counted at every rising edge so none slips by
  always @(posedge clock) begin
    if (reception_complete_req === 1'b1) done_cnt++;
    if (receive_error_irq === 1'b1) irq_cnt++;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
      input string msg);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask
  // waits a bounded time for a byte, then takes it with one ready cycle
  task automatic pop(output logic got);
    int n;
    n = 0;
    got = 1'b0;
    @(negedge clock);
    while (rx_valid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (rx_valid === 1'b1) begin
      got = 1'b1;
      got_byte = rx_data;
      @(posedge clock) rx_ready <= 1'b1;
      @(posedge clock) rx_ready <= 1'b0;
    end
  endtask
  // empties the fifo; with cmp set, bytes must match the sent order
  task automatic drain(input logic cmp);
    logic g;
    g = 1'b1;
    while (g) begin
      pop(g);
      if (g && cmp) check({8'h00, got_byte}, {8'h00, exp_q.pop_front()},
        "byte");
    end
    if (cmp) check(16'(exp_q.size()), 16'h0000, "missing");
  endtask
  task automatic tx_byte(input logic [7:0] d, input logic keep);
    tx.send(d, parity_enable, parity_odd, 1'b0, 1'b1);
    if (keep) exp_q.push_back(d);
  endtask
  task automatic clear_flags;
    @(posedge clock) flag_clear <= 1'b1;
    @(posedge clock) flag_clear <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // a hang anywhere ends the run well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict;
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    {channel_start_bit, standby_wake_ctrl_bit, deep_halt} = 3'h0;
    {fast_osc_selected, error_irq_enable_bit, parity_enable} = 3'h0;
    {standby_error_suppress_bit, parity_odd, flag_clear} = 3'h0;
    rx_ready = 1'b0;
    prescaler_select_reg = 3'h0;
    channel_data_reg = 16'h0600;
    lfsr = 32'h0000_e4d0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    channel_start_bit <= 1'b1;
    error_irq_enable_bit <= 1'b1;
    repeat (6) @(posedge clock);
    // normal mode: corner and random bytes back to back
    tx_byte(8'h00, 1'b1);
    tx_byte(8'hff, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      tx_byte(lfsr[7:0], 1'b1);
    end
    drain(1'b1);
    // prescaler 1 with field 1 keeps 8 clocks a bit through the shift
    @(posedge clock);
    prescaler_select_reg <= 3'h1;
    channel_data_reg <= 16'h0200;
    @(posedge clock);
    lfsr = lfsr_next(lfsr);
    tx_byte(lfsr[7:0], 1'b1);
    drain(1'b1);
    // odd parity good, then even parity: an error with irq on and a
    // framing error with irq off; settings land an edge before use
    @(posedge clock);
    parity_enable <= 1'b1;
    parity_odd <= 1'b1;
    @(posedge clock);
    tx_byte(8'ha5, 1'b1);
    drain(1'b1);
    @(posedge clock) parity_odd <= 1'b0;
    tx.send(8'h3c, 1'b1, 1'b0, 1'b1, 1'b1);
    @(negedge clock);
    check(16'(parity_error_flag), 16'h0001, "parity flag");
    check(16'(irq_cnt), 16'h0001, "irq count");
    @(posedge clock) error_irq_enable_bit <= 1'b0;
    tx.send(8'h5a, 1'b1, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    check(16'(framing_error_flag), 16'h0001, "framing flag");
    check(16'(irq_cnt), 16'h0001, "masked irq");
    drain(1'b0);
    clear_flags();
    @(negedge clock);
    check({13'h0000, parity_error_flag, framing_error_flag,
      overrun_error_flag}, 16'h0000, "flags cleared");
    // output stage and all 16 places fill with the reader stalled;
    // the 18th frame overruns
    @(posedge clock);
    parity_enable <= 1'b0;
    error_irq_enable_bit <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 17; i++) begin
      lfsr = lfsr_next(lfsr);
      tx_byte(lfsr[7:0], 1'b1);
    end
    tx_byte(8'h77, 1'b0);
    @(negedge clock);
    check(16'(overrun_error_flag), 16'h0001, "overrun flag");
    check(16'(irq_cnt), 16'h0002, "overrun irq");
    drain(1'b1);
    clear_flags();
    // wake bit set outside halt: the frame is not taken
    standby_wake_ctrl_bit <= 1'b1;
    tx.send(8'h81, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge clock);
    check(16'(rx_valid), 16'h0000, "taken outside halt");
    // halted on a slow clock source: standby is never reached
    @(posedge clock) deep_halt <= 1'b1;
    repeat (500) @(posedge clock);
    @(negedge clock);
    check(16'(standby_active), 16'h0000, "standby wrong osc");
    // fast oscillator: standby only after the 450-cycle transition delay
    fast_osc_selected <= 1'b1;
    repeat (440) @(posedge clock);
    @(negedge clock);
    check(16'(standby_active), 16'h0000, "standby early");
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(16'(standby_active), 16'h0001, "standby late");
    tx_byte(8'hc3, 1'b1);
    drain(1'b1);
    check(16'(done_cnt), 16'h0001, "completion pulses");
    // suppression in standby hides a framing error and its irq
    @(posedge clock) standby_error_suppress_bit <= 1'b1;
    tx.send(8'h18, 1'b0, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    check(16'(framing_error_flag), 16'h0000, "suppressed flag");
    check(16'(irq_cnt), 16'h0002, "suppressed irq");
    drain(1'b0);
    print_verdict;
  end
endmodule // uswr_receiver_test
